// ===== ebs_mem_model.sv
// external memory with byte lanes and slow ready
`timescale 1ns/1ns
`default_nettype none
module ebs_mem_model (
  input wire logic CORE_CLK,
  input wire logic HALF_RATE_CLK_OUT,
  input wire logic ADDR_VALID_N,
  input wire logic READ_STROBE_N,
  input wire logic UPPER_LANE_SELECT_N,
  input wire logic [15:0] AD_OUT,
  input wire logic [15:0] AD_OE_N,
  input wire logic [2:0] waits,
  output logic READY,
  output logic [15:0] AD_IN
);
  logic [15:0] mem [16];
  logic [15:0] a;
  logic [2:0] cnt = 0;
  logic [1:0] ph = 0;
  logic hr = 0;
  assign AD_IN = (AD_OUT | AD_OE_N) & (READ_STROBE_N ? 16'hffff : mem[a[4:1]]);
  assign READY = (cnt == 3'h0);
  always @(posedge CORE_CLK)
  begin
    hr <= HALF_RATE_CLK_OUT;
    if (ADDR_VALID_N)
    begin
      ph <= 0;
      cnt <= 0;
    end
    else if (ph == 0)
    begin
      ph <= 1;
      a <= AD_IN;
      cnt <= waits;
    end
    else if (ph == 1)
      ph <= 2;
    else
    begin
      if (HALF_RATE_CLK_OUT && !hr && cnt != 0)
        cnt <= cnt - 1;
      if (READ_STROBE_N && !a[0] && AD_OE_N !== 16'hffff)
        mem[a[4:1]][7:0] <= AD_IN[7:0];
      if (READ_STROBE_N && !UPPER_LANE_SELECT_N && AD_OE_N !== 16'hffff)
        mem[a[4:1]][15:8] <= AD_IN[15:8];
    end
  end
endmodule
`default_nettype wire

// ===== ebs_pkg.sv
// constants and types of the external bus strobe block
package ebs_pkg;

  // register byte offsets
  localparam logic [7:0] EBS_OFF_CFG = 8'h00;
  localparam logic [7:0] EBS_OFF_CFGB = 8'h04;
  localparam logic [7:0] EBS_OFF_PORT = 8'h08;
  localparam logic [7:0] EBS_OFF_EXTP = 8'h0c;
  localparam logic [7:0] EBS_OFF_STAT = 8'h10;

  // chip_config_reg fields
  localparam int CFG_WR_LOW = 0;
  localparam int CFG_WIDTH = 1;
  localparam int CFG_UP_WRH = 2;
  localparam int CFG_WR_EN = 3;
  localparam int CFG_UP_EN = 4;
  localparam int CFG_RDY_EN = 5;
  localparam int CFG_RD_EN = 6;
  localparam int CFG_ADV_EN = 7;
  localparam int CFG_WAIT_LO = 8;
  localparam int CFG_W = 10;

  // chip_config_reg_b fields
  localparam int CFGB_WIDTH = 2;
  localparam int CFGB_WAIT_HI = 3;
  localparam int CFGB_W = 4;

  // port register fields
  localparam int PORT_PIN_WR = 0;
  localparam int PORT_PIN_UP = 1;
  localparam int PORT_PIN_RD = 2;
  localparam int PORT_PIN_ADV = 3;
  localparam int PORT_AD_LSB = 16;

  // extended port register fields
  localparam int EXTP_SEL_LSB = 8;
  localparam int EXT_ADDR_LINES = 4;
  localparam int EXT_ADDR_LSB = 16;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_GRANT = 1;
  localparam int STAT_IRQ = 2;
  localparam int STAT_WAIT_LSB = 3;
  localparam int STAT_READY = 6;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RST = 10'h002;
  localparam logic [CFGB_W-1:0] CFGB_RST = 4'h0;
  localparam logic [3:0] PINS_RST = 4'hf;
  localparam logic [15:0] AD_PORT_RST = 16'hffff;
  localparam logic [7:0] EXT_OUT_RST = 8'hff;
  localparam logic [3:0] EXT_SEL_RST = 4'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT} ebs_state_e;

endpackage

// ===== ebs_strobes.sv
// external bus controller: strobes, byte lanes, wait states and pins
//
// Overview of operation
// R1: config picks full write strobe or low-lane strobe; otherwise plain port pin.
// R2: full write-strobe mode drives strobe low on every external write.
// R3: low-lane mode drives strobe low only when an even byte is stored.
// R4: write strobe only in external write cycles, never internal accesses.
// R5: byte-enable mode: low A0=0/sel=1, high A0=1/sel=0, both 0/0.
// R6: high-lane write mode drives pin low writing an odd address.
// R7: upper-lane pin valid only in 16-bit cycles; plain port pin otherwise.
// R8: ready low before clock-out fall inserts waits until rising edge with ready.
// R9: ready high means external cycles run without wait states.
// R10: ready ignored when no external access is in progress.
// R11: wait states per cycle limited by fields of both config registers.
// R12: address/data on two 8-bit open-drain ports, strongly driven on bus use.
// R13: A16-A19 on extended port, each pin address line or plain I/O.
// R14: active-low output shows a pending interrupt needs the bus.
// R15: dynamic width: width input low gives 8-bit, high gives 16-bit cycle.
// R16: read strobe only in external read cycles; otherwise plain port pin.
// R17: address-valid strobe goes inactive high at end of each cycle.
// R18: hold grant output shows bus released after a hold request.
// R19: wait count per cycle ends the cycle at the maximum, ready ignored.
// R20: memory pulls ready low before clock-out falls when it needs time.
`timescale 1ns/1ns
`default_nettype none
module ebs_strobes
  import ebs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic XREQ,
  input wire logic XEXT,
  input wire logic XWRITE,
  input wire logic XWORD,
  input wire logic [19:0] XADDR,
  input wire logic [15:0] XWDATA,
  output logic XREADY,
  output logic XACK,
  output logic [15:0] XRDATA,
  output logic HALF_RATE_CLK_OUT,
  output logic WRITE_STROBE_N,
  output logic UPPER_LANE_SELECT_N,
  output logic READ_STROBE_N,
  output logic ADDR_VALID_N,
  input wire logic READY,
  input wire logic BUS_WIDTH,
  input wire logic [15:0] AD_IN,
  output logic [15:0] AD_OUT,
  output logic [15:0] AD_OE_N,
  output logic [7:0] EXT_PORT_OUT,
  input wire logic HOLD_REQ_N,
  output logic HOLD_GRANT_N,
  input wire logic IRQ_NEEDS_BUS,
  output logic IRQ_BUS_NEED_N
);

  typedef struct packed {
    ebs_state_e st;
    logic div;
    logic [CFG_W-1:0] cfg;
    logic [CFGB_W-1:0] cfgb;
    logic [3:0] pins;
    logic [15:0] ad_port;
    logic [7:0] ext_out;
    logic [EXT_ADDR_LINES-1:0] ext_sel;
    logic [2:0] wait_cnt;
    logic [2:0] last_wait;
    logic rdy_low;
    logic wr;
    logic word;
    logic w16;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic grant;
    logic irq;
    logic [31:0] prdata;
    logic perr;
    logic wr_n;
    logic up_n;
    logic rd_n;
    logic adv_n;
    logic [15:0] ad_out;
    logic [15:0] ad_oe_n;
    logic [7:0] ext_pins;
  } ebs_st_s;

  ebs_st_s s;
  ebs_st_s next_s;

  // cycle width from the two config bits and the width input
  function automatic logic width16(input logic [CFG_W-1:0] c, input logic [CFGB_W-1:0] cb,
                                   input logic bw);
    if (c[CFG_WIDTH] && cb[CFGB_WIDTH])
      width16 = bw;
    else
      width16 = c[CFG_WIDTH];
  endfunction

  // upper lane touched by this access
  function automatic logic upper_lane(input logic w16, input logic word, input logic a0);
    upper_lane = w16 && (word || a0);
  endfunction

  logic rise;
  logic start;
  logic finish;
  logic bus_act;
  logic strobe;
  logic [2:0] wait_max;
  logic [31:0] rd_mux;
  logic unmapped;

  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.div = ~s.div;
    rise = ~s.div;
    finish = 1'b0;
    wait_max = {s.cfgb[CFGB_WAIT_HI], s.cfg[CFG_WAIT_LO+1:CFG_WAIT_LO]};
    next_s.irq = IRQ_NEEDS_BUS;
    unmapped = !(PADDR == EBS_OFF_CFG || PADDR == EBS_OFF_CFGB || PADDR == EBS_OFF_PORT
                 || PADDR == EBS_OFF_EXTP || PADDR == EBS_OFF_STAT);
    rd_mux = 32'h0;
    unique case (PADDR)
      EBS_OFF_CFG: rd_mux[CFG_W-1:0] = s.cfg;
      EBS_OFF_CFGB: rd_mux[CFGB_W-1:0] = s.cfgb;
      EBS_OFF_PORT: rd_mux = {s.ad_port, 12'h000, s.pins};
      EBS_OFF_EXTP: rd_mux = {20'h00000, s.ext_sel, s.ext_out};
      EBS_OFF_STAT:
      begin
        rd_mux[STAT_BUSY] = s.st != ST_IDLE;
        rd_mux[STAT_GRANT] = s.grant;
        rd_mux[STAT_IRQ] = s.irq;
        rd_mux[STAT_WAIT_LSB+2:STAT_WAIT_LSB] = s.last_wait;
        rd_mux[STAT_READY] = READY;
      end
      default: rd_mux = 32'h0;
    endcase
    if (PSEL && !PENABLE)
    begin
      next_s.prdata = PWRITE ? 32'h0 : rd_mux;
      next_s.perr = unmapped;
    end
    if (PSEL && PENABLE && PWRITE)
    begin
      unique case (PADDR)
        EBS_OFF_CFG: next_s.cfg = PWDATA[CFG_W-1:0];
        EBS_OFF_CFGB: next_s.cfgb = PWDATA[CFGB_W-1:0];
        EBS_OFF_PORT:
        begin
          next_s.pins = PWDATA[3:0];
          next_s.ad_port = PWDATA[PORT_AD_LSB+15:PORT_AD_LSB];
        end
        EBS_OFF_EXTP:
        begin
          next_s.ext_out = PWDATA[7:0];
          next_s.ext_sel = PWDATA[EXTP_SEL_LSB+EXT_ADDR_LINES-1:EXTP_SEL_LSB];
        end
        default: next_s.perr = s.perr;
      endcase
    end
    // R18 hold grant
    if (HOLD_REQ_N)
      next_s.grant = 1'b0;
    else if (s.st == ST_IDLE && rise)
      next_s.grant = 1'b1;
    start = XREQ && s.st == ST_IDLE && rise && !s.grant && HOLD_REQ_N;
    unique case (s.st)
      ST_IDLE:
      begin
        if (start)
        begin
          next_s.wr = XWRITE;
          next_s.word = XWORD;
          next_s.addr = XADDR;
          next_s.wdata = XWDATA;
          next_s.wait_cnt = 3'h0;
          next_s.rdy_low = 1'b0;
          // R15 cycle width
          next_s.w16 = width16(s.cfg, s.cfgb, BUS_WIDTH);
          // R4 internal access
          if (XEXT)
            next_s.st = ST_ADDR;
          else
            next_s.ack = 1'b1;
        end
      end
      ST_ADDR:
      begin
        if (rise)
          next_s.st = ST_DATA;
      end
      ST_DATA:
      begin
        // R8 R10 ready sampled in data
        if (!rise)
          next_s.rdy_low = s.cfg[CFG_RDY_EN] && !READY;
        else if (s.rdy_low && wait_max != 3'h0)
        begin
          next_s.st = ST_WAIT;
          next_s.wait_cnt = 3'h1;
        end
        else
          // R9 no wait inserted
          finish = 1'b1;
      end
      ST_WAIT:
      begin
        if (rise)
        begin
          // R11 R19 wait limit
          if (READY || s.wait_cnt == wait_max)
            finish = 1'b1;
          else
            next_s.wait_cnt = s.wait_cnt + 3'h1;
        end
      end
    endcase
    if (finish)
    begin
      next_s.st = ST_IDLE;
      next_s.ack = 1'b1;
      next_s.last_wait = s.wait_cnt;
      if (s.wr)
        next_s.rdata = s.rdata;
      else if (s.w16 && s.word)
        next_s.rdata = AD_IN;
      else if (s.w16 && s.addr[0])
        next_s.rdata = {8'h00, AD_IN[15:8]};
      else
        next_s.rdata = {8'h00, AD_IN[7:0]};
    end
    bus_act = next_s.st != ST_IDLE;
    strobe = next_s.st == ST_DATA || next_s.st == ST_WAIT;
    // R17 address valid ends with cycle
    next_s.adv_n = s.cfg[CFG_ADV_EN] ? !bus_act : s.pins[PORT_PIN_ADV];
    // R16 read strobe
    next_s.rd_n = s.cfg[CFG_RD_EN] ? !(strobe && !next_s.wr) : s.pins[PORT_PIN_RD];
    // R1 write pin function
    if (!s.cfg[CFG_WR_EN])
      next_s.wr_n = s.pins[PORT_PIN_WR];
    else if (s.cfg[CFG_WR_LOW])
      // R3 R4 low-lane store
      next_s.wr_n = !(strobe && next_s.wr && (!next_s.addr[0] || (next_s.w16 && next_s.word)));
    else
      // R2 R4 full write strobe
      next_s.wr_n = !(strobe && next_s.wr);
    // R7 upper pin function
    if (!s.cfg[CFG_UP_EN])
      next_s.up_n = s.pins[PORT_PIN_UP];
    else if (s.cfg[CFG_UP_WRH])
      // R6 high-lane store
      next_s.up_n = !(strobe && next_s.wr
                      && upper_lane(next_s.w16, next_s.word, next_s.addr[0]));
    else
      // R5 upper lane select
      next_s.up_n = !(bus_act && upper_lane(next_s.w16, next_s.word, next_s.addr[0]));
    // R12 address/data ports
    if (next_s.st == ST_ADDR)
    begin
      next_s.ad_out = next_s.addr[15:0];
      next_s.ad_oe_n = 16'h0000;
    end
    else if (strobe && next_s.wr)
    begin
      if (!next_s.w16)
      begin
        next_s.ad_out = {8'hff, next_s.wdata[7:0]};
        next_s.ad_oe_n = 16'hff00;
      end
      else if (!next_s.word && next_s.addr[0])
      begin
        next_s.ad_out = {next_s.wdata[7:0], next_s.wdata[7:0]};
        next_s.ad_oe_n = 16'h0000;
      end
      else
      begin
        next_s.ad_out = next_s.wdata;
        next_s.ad_oe_n = 16'h0000;
      end
    end
    else if (strobe || next_s.grant)
    begin
      next_s.ad_out = 16'hffff;
      next_s.ad_oe_n = 16'hffff;
    end
    else
    begin
      // open drain: only zeros are driven
      next_s.ad_out = next_s.ad_port;
      next_s.ad_oe_n = next_s.ad_port;
    end
    // R13 extended address lines
    next_s.ext_pins = next_s.ext_out;
    for (int i = 0; i < EXT_ADDR_LINES; i++)
    begin
      if (next_s.ext_sel[i] && bus_act)
        next_s.ext_pins[i] = next_s.addr[EXT_ADDR_LSB+i];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cfg <= CFG_RST;
      s.cfgb <= CFGB_RST;
      s.pins <= PINS_RST;
      s.ad_port <= AD_PORT_RST;
      s.ext_out <= EXT_OUT_RST;
      s.ext_sel <= EXT_SEL_RST;
      s.wr_n <= 1'b1;
      s.up_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.adv_n <= 1'b1;
      s.ad_out <= AD_PORT_RST;
      s.ad_oe_n <= AD_PORT_RST;
      s.ext_pins <= EXT_OUT_RST;
    end
    else
      s <= next_s;
  end

  assign PRDATA = s.prdata;
  assign PREADY = PENABLE;
  assign PSLVERR = PSEL && PENABLE && s.perr;
  assign XREADY = s.st == ST_IDLE && !s.div && !s.grant && HOLD_REQ_N;
  assign XACK = s.ack;
  assign XRDATA = s.rdata;
  assign HALF_RATE_CLK_OUT = s.div;
  assign WRITE_STROBE_N = s.wr_n;
  assign UPPER_LANE_SELECT_N = s.up_n;
  assign READ_STROBE_N = s.rd_n;
  assign ADDR_VALID_N = s.adv_n;
  assign AD_OUT = s.ad_out;
  assign AD_OE_N = s.ad_oe_n;
  assign EXT_PORT_OUT = s.ext_pins;
  assign HOLD_GRANT_N = !s.grant;
  // R14 interrupt needs bus
  assign IRQ_BUS_NEED_N = !s.irq;

endmodule
`default_nettype wire

// ===== ebs_strobes_sva.sv
// assertions on the external bus strobe block
`timescale 1ns/1ns
`default_nettype none
module ebs_strobes_sva (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic HALF_RATE_CLK_OUT,
  input wire logic XREQ,
  input wire logic XEXT,
  input wire logic XREADY,
  input wire logic XACK,
  input wire logic READY,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic ADDR_VALID_N,
  input wire logic HOLD_REQ_N,
  input wire logic HOLD_GRANT_N,
  input wire logic IRQ_NEEDS_BUS,
  input wire logic IRQ_BUS_NEED_N
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  chk_wr_in_cycle: assert property ($fell(WRITE_STROBE_N) |-> !ADDR_VALID_N && READ_STROBE_N)
    else $error("write strobe outside a write cycle");
  chk_rd_in_cycle: assert property ($fell(READ_STROBE_N) |-> !ADDR_VALID_N && WRITE_STROBE_N)
    else $error("read strobe outside a read cycle");
  chk_adv_end: assert property (XACK |-> ADDR_VALID_N && WRITE_STROBE_N && READ_STROBE_N)
    else $error("strobes still active at cycle end");
  chk_no_wait: assert property (XREQ && XREADY && XEXT ##1 READY [*4] |=> XACK)
    else $error("wait inserted with ready high");
  chk_wait_bound: assert property (XREQ && XREADY && XEXT |-> ##[1:19] XACK)
    else $error("bus cycle exceeds wait limit");
  chk_irq_out: assert property (IRQ_NEEDS_BUS |=> !IRQ_BUS_NEED_N)
    else $error("bus need output not asserted");
  chk_hold_free: assert property (HOLD_REQ_N |=> HOLD_GRANT_N)
    else $error("grant held without request");
  chk_hold_bus: assert property (!HOLD_GRANT_N |-> ADDR_VALID_N && !XREADY)
    else $error("bus used while granted away");
  chk_clk_toggle: assert property ($past(RESETN)
    |-> HALF_RATE_CLK_OUT != $past(HALF_RATE_CLK_OUT))
    else $error("clock output did not toggle");
  cover property (XREQ && XREADY && XEXT);
  cover property (!READY && !ADDR_VALID_N);
  cover property (!HOLD_GRANT_N);
endmodule
bind ebs_strobes ebs_strobes_sva chk (
  .CORE_CLK(CORE_CLK),
  .RESETN(RESETN),
  .HALF_RATE_CLK_OUT(HALF_RATE_CLK_OUT),
  .XREQ(XREQ),
  .XEXT(XEXT),
  .XREADY(XREADY),
  .XACK(XACK),
  .READY(READY),
  .WRITE_STROBE_N(WRITE_STROBE_N),
  .READ_STROBE_N(READ_STROBE_N),
  .ADDR_VALID_N(ADDR_VALID_N),
  .HOLD_REQ_N(HOLD_REQ_N),
  .HOLD_GRANT_N(HOLD_GRANT_N),
  .IRQ_NEEDS_BUS(IRQ_NEEDS_BUS),
  .IRQ_BUS_NEED_N(IRQ_BUS_NEED_N)
);
`default_nettype wire

// ===== ebs_strobes_test.sv
// self-checking bench of the external bus strobe block
`timescale 1ns/1ns
`default_nettype none
module ebs_strobes_test
  import ebs_pkg::*;
;
  logic CORE_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, XREQ = 0, XEXT = 0;
  logic XWRITE = 0, XWORD = 0, BUS_WIDTH = 1, HOLD_REQ_N = 1, IRQ_NEEDS_BUS = 0, err;
  logic [7:0] PADDR = 0, EXT_PORT_OUT;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [19:0] XADDR = 0;
  logic [15:0] XWDATA = 0, XRDATA, AD_IN, AD_OUT, AD_OE_N;
  logic [3:0] ext_seen;
  logic [2:0] waits = 0;
  logic PREADY, PSLVERR, XREADY, XACK, HALF_RATE_CLK_OUT, WRITE_STROBE_N, UPPER_LANE_SELECT_N;
  logic READ_STROBE_N, ADDR_VALID_N, READY, HOLD_GRANT_N, IRQ_BUS_NEED_N;
  int num_errors = 0, cmp_count = 0, cyc = 0, wrf = 0, upf = 0;
  ebs_strobes dut (
    .CORE_CLK(CORE_CLK),
    .RESETN(RESETN),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .XREQ(XREQ),
    .XEXT(XEXT),
    .XWRITE(XWRITE),
    .XWORD(XWORD),
    .XADDR(XADDR),
    .XWDATA(XWDATA),
    .XREADY(XREADY),
    .XACK(XACK),
    .XRDATA(XRDATA),
    .HALF_RATE_CLK_OUT(HALF_RATE_CLK_OUT),
    .WRITE_STROBE_N(WRITE_STROBE_N),
    .UPPER_LANE_SELECT_N(UPPER_LANE_SELECT_N),
    .READ_STROBE_N(READ_STROBE_N),
    .ADDR_VALID_N(ADDR_VALID_N),
    .READY(READY),
    .BUS_WIDTH(BUS_WIDTH),
    .AD_IN(AD_IN),
    .AD_OUT(AD_OUT),
    .AD_OE_N(AD_OE_N),
    .EXT_PORT_OUT(EXT_PORT_OUT),
    .HOLD_REQ_N(HOLD_REQ_N),
    .HOLD_GRANT_N(HOLD_GRANT_N),
    .IRQ_NEEDS_BUS(IRQ_NEEDS_BUS),
    .IRQ_BUS_NEED_N(IRQ_BUS_NEED_N)
  );
  ebs_mem_model mem (
    .CORE_CLK(CORE_CLK),
    .HALF_RATE_CLK_OUT(HALF_RATE_CLK_OUT),
    .ADDR_VALID_N(ADDR_VALID_N),
    .READ_STROBE_N(READ_STROBE_N),
    .UPPER_LANE_SELECT_N(UPPER_LANE_SELECT_N),
    .AD_OUT(AD_OUT),
    .AD_OE_N(AD_OE_N),
    .waits(waits),
    .READY(READY),
    .AD_IN(AD_IN)
  );
  always #50 CORE_CLK = ~CORE_CLK;
  always @(negedge WRITE_STROBE_N) wrf++;
  always @(negedge UPPER_LANE_SELECT_N) upf++;
  always @(posedge CORE_CLK) if (!ADDR_VALID_N) ext_seen <= EXT_PORT_OUT[3:0];
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) @(posedge CORE_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic xacc(input logic e, w, wd, input logic [19:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    XREQ <= 1;
    XEXT <= e;
    XWRITE <= w;
    XWORD <= wd;
    XADDR <= a;
    XWDATA <= d;
    @(posedge CORE_CLK);
    while (XREADY !== 1'b1) @(posedge CORE_CLK);
    XREQ <= 0;
    @(posedge CORE_CLK);
    while (XACK !== 1'b1) @(posedge CORE_CLK);
  endtask
  initial
  begin
    repeat (4) @(posedge CORE_CLK);
    RESETN <= 1;
    apb(0, EBS_OFF_CFG, 0);
    chk(rd, 32'h002);
    apb(0, EBS_OFF_PORT, 0);
    chk(rd, 32'hffff000f);
    apb(0, 8'h14, 0);
    chk(32'(err), 1);
    $display("test reset done");
    apb(1, EBS_OFF_CFG, 32'h2fa);
    xacc(1, 1, 1, 20'h00004, 16'ha55a);
    chk(32'(wrf), 1);
    xacc(1, 0, 1, 20'h00004, 0);
    chk(32'(XRDATA), 32'ha55a);
    apb(0, EBS_OFF_STAT, 0);
    chk(32'(rd[5:3]), 0);
    xacc(0, 1, 1, 20'h00004, 16'h1111);
    chk(32'(wrf), 1);
    xacc(1, 1, 0, 20'h00005, 16'h0077);
    chk(32'(upf), 3);
    xacc(1, 1, 0, 20'h00006, 16'h0066);
    chk(32'(upf), 3);
    apb(1, EBS_OFF_CFGB, 32'h4);
    BUS_WIDTH <= 0;
    xacc(1, 1, 1, 20'h00008, 16'h1234);
    chk(32'(upf), 3);
    apb(1, EBS_OFF_CFGB, 0);
    $display("test lanes done");
    apb(1, EBS_OFF_CFG, 32'h2fb);
    xacc(1, 1, 0, 20'h00005, 16'h0011);
    chk(32'(wrf), 4);
    xacc(1, 1, 0, 20'h00004, 16'h0022);
    chk(32'(wrf), 5);
    apb(1, EBS_OFF_CFG, 32'h2fe);
    xacc(1, 0, 0, 20'h00005, 0);
    chk(32'(upf), 4);
    xacc(1, 1, 0, 20'h00005, 16'h0033);
    chk(32'(upf), 5);
    $display("test strobes done");
    waits <= 7;
    xacc(1, 0, 1, 20'h00004, 0);
    apb(0, EBS_OFF_STAT, 0);
    chk(32'(rd[5:3]), 2);
    apb(1, EBS_OFF_CFG, 32'h0fe);
    apb(1, EBS_OFF_CFGB, 32'h8);
    xacc(1, 0, 1, 20'h00004, 0);
    apb(0, EBS_OFF_STAT, 0);
    chk(32'(rd[5:3]), 4);
    waits <= 0;
    apb(1, EBS_OFF_EXTP, 32'hfff);
    xacc(1, 0, 1, 20'h50004, 0);
    chk(32'(ext_seen), 5);
    $display("test waits done");
    IRQ_NEEDS_BUS <= 1;
    repeat (2) @(posedge CORE_CLK);
    chk(32'(IRQ_BUS_NEED_N), 0);
    HOLD_REQ_N <= 0;
    repeat (4) @(posedge CORE_CLK);
    chk(32'(HOLD_GRANT_N), 0);
    HOLD_REQ_N <= 1;
    apb(1, EBS_OFF_PORT, 32'h00ff000f);
    repeat (2) @(posedge CORE_CLK);
    chk(32'(AD_OE_N), 32'h00ff);
    chk(32'(AD_OUT), 32'h00ff);
    $display("test pins done");
    conclude();
  end
endmodule
`default_nettype wire
